// *** src/arid_dev.sv ***
// Device end: result double buffer, read checksum, register lock, config checksum
`timescale 1ns/10ps
// Behaviour
// - Channel results sit behind two cascaded latches
// - First latch captures on ready; link captures all
// - Second latch freezes result when read starts
// - Host reads every bit before next channel
// - Host waits output delay after ready falls
// - Host may poll ready flags instead
// - Checksum appended after read sequence when enabled
// - Read checksum is CRC-16, polynomial 0x8005
// - Width bit selects 32-bit or 16-bit checksum format
// - Host matches checksum width to data width
// - Host expects zero remainder, else aborts
// - Checksum only after last address of set
// - Lock field at 0x1F, 0xA5 unlocks writes
// - Locked map ignores writes except to 0x1F
// - Config checksum only while locked, else zero
// - Config checksum recomputed every 12 cycles
// - Config checksum cleared by reset
// - Message covers 0x09-0x1F, flags ones, checksum zeros
// - Mismatch with irq enabled latches ready pin low
// - Unlock clears flag; reset leaves map unlocked
// - Refused write leaves address pointer unchanged
// - Ready pin pulses low per conversion
module arid_dev
  import arid_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  arid_if.dev lnk,
  input wire logic [1:0][23:0] ch_result,
  input wire logic [1:0] chan_ready,
  output logic map_locked,
  output logic cfg_irq,
  output logic [15:0] config_checksum
);
  arid_dev_state_type state;
  logic [2:0] sck_q;
  logic [1:0] cs_q;
  logic [1:0] sdi_q;
  logic sck_rise;
  logic sck_fall;
  logic cs_act;
  logic sdi_s;
  logic [23:0] cfg [CFG_LO:CFG_HI];
  logic [7:0] lock;
  logic locked;
  logic [23:0] status;
  logic [1:0] channel_ready_flags;
  logic [23:0] res_hold [2];
  logic [5:0] bitcnt;
  logic [31:0] shreg;
  logic [4:0] ptr;
  logic [15:0] read_sequence_checksum;
  logic crc_pend;
  logic [23:0] rd_word;
  logic [4:0] next_rd;
  logic rd_last;
  logic [4:0] next_wr;
  logic wr_go;
  logic wr_ok;
  logic [23:0] wr_data;
  logic load;
  logic [3:0] crc_k;
  logic [15:0] crc_acc;
  logic [15:0] next_acc;
  logic [15:0] crc_ref;
  logic ref_valid;

  // Link pins are asynchronous to the master clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_q <= 3'h0;
      cs_q <= 2'h3;
      sdi_q <= 2'h0;
    end else begin
      sck_q <= {sck_q[1:0], lnk.sck};
      cs_q <= {cs_q[0], lnk.cs_n};
      sdi_q <= {sdi_q[0], lnk.sdi};
    end
  end

  assign sck_rise = sck_q[1] & ~sck_q[2];
  assign sck_fall = ~sck_q[1] & sck_q[2];
  assign cs_act = ~cs_q[1];
  assign sdi_s = sdi_q[1];
  assign locked = (lock != LOCK_PASSWORD);
  assign status = cfg[ADDR_STATUS];

  function automatic logic [23:0] word_at(input logic [4:0] a, input logic for_msg);
    if (a == ADDR_LOCK) begin
      return {lock, for_msg ? 16'h0000 : config_checksum};
    end else if (a == ADDR_STATUS) begin
      return {status[23:22], for_msg ? 6'h3F : {4'hF, channel_ready_flags}, status[15:0]};
    end else if (a >= ADDR_CFG_FIRST) begin
      return cfg[a];
    end else if (a == ADDR_CH0 || a == ADDR_CH1) begin
      return res_hold[a[0]];
    end
    return 24'h000000;
  endfunction : word_at

  // Stage one, per channel, on the master clock
  for (genvar i = 0; i < 2; i++) begin : g_chan
    logic take;
    logic read_start;
    assign take = chan_ready[i] | (status[ST_LINK] & (|chan_ready));
    assign read_start = load && !crc_pend && ptr == 5'(i);
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        res_hold[i] <= 24'h000000;
        channel_ready_flags[i] <= 1'b1;
      end else if (take) begin
        res_hold[i] <= ch_result[i];
        channel_ready_flags[i] <= 1'b0;
      end else if (read_start) begin
        channel_ready_flags[i] <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_word = word_at(ptr, 1'b0);
    next_rd = 5'(ptr + 5'h01);
    rd_last = 1'b0;
    case (status[ST_READ_LSB +: 2])
      RD_STATIC: begin
        next_rd = ptr;
        rd_last = 1'b1;
      end
      RD_FULL: begin
        rd_last = (ptr == ADDR_LOCK);
        if (rd_last) begin
          next_rd = ADDR_CH0;
        end else if (ptr == ADDR_CH1) begin
          next_rd = ADDR_CFG_FIRST;
        end
      end
      default: begin
        rd_last = (ptr == ADDR_CH1) || (ptr == ADDR_LOCK);
        if (rd_last) begin
          next_rd = (ptr == ADDR_CH1) ? ADDR_CH0 : ADDR_CFG_FIRST;
        end
      end
    endcase
  end

  assign next_wr = !status[ST_WRITE] ? ptr : (ptr == ADDR_LOCK) ? ADDR_CFG_FIRST : 5'(ptr + 5'h01);
  assign wr_go = cs_act && state == DEV_WRITE && sck_rise && bitcnt == BITS_WORD_LAST;
  assign wr_data = {shreg[22:0], sdi_s};
  assign wr_ok = (ptr == ADDR_LOCK) || (!locked && ptr >= ADDR_CFG_FIRST);
  assign load = cs_act && state == DEV_READ && sck_fall && bitcnt == 6'h00;

  // Serial engine; sdo changes on the falling edge, sdi sampled on the rising
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= DEV_IDLE;
      bitcnt <= 6'h00;
      shreg <= 32'h00000000;
      ptr <= 5'h00;
      read_sequence_checksum <= 16'h0000;
      crc_pend <= 1'b0;
      lnk.sdo <= 1'b0;
      lnk.sdo_oe <= 1'b0;
    end else if (!cs_act) begin
      state <= DEV_IDLE;
      bitcnt <= 6'h00;
      crc_pend <= 1'b0;
      read_sequence_checksum <= 16'h0000;
      lnk.sdo_oe <= 1'b0;
    end else begin
      case (state)
        DEV_IDLE: begin
          state <= DEV_CTRL;
          bitcnt <= 6'h00;
        end
        DEV_CTRL: begin
          if (sck_rise) begin
            shreg <= {shreg[30:0], sdi_s};
            bitcnt <= 6'(bitcnt + 6'h01);
            if (bitcnt == BITS_CTRL_LAST) begin
              ptr <= shreg[4:0];
              state <= sdi_s ? DEV_READ : DEV_WRITE;
              bitcnt <= 6'h00;
            end
          end
        end
        DEV_READ: begin
          lnk.sdo_oe <= 1'b1;
          if (load && crc_pend) begin
            lnk.sdo <= read_sequence_checksum[15];
            shreg <= {read_sequence_checksum[14:0], 17'h00000};
            bitcnt <= status[ST_WIDTH1] ? BITS_CRC32_LAST : BITS_CRC16_LAST;
            read_sequence_checksum <= 16'h0000;
            crc_pend <= 1'b0;
          end else if (load) begin
            // Word frozen in the shifter for the whole read
            lnk.sdo <= rd_word[23];
            shreg <= {rd_word[22:0], 9'h000};
            bitcnt <= BITS_WORD_LAST;
            read_sequence_checksum <= arid_crc_step(read_sequence_checksum, {8'h00, rd_word}, DATA_W);
            crc_pend <= status[ST_RSUM_EN] && rd_last;
            ptr <= next_rd;
          end else if (sck_fall) begin
            lnk.sdo <= shreg[31];
            shreg <= {shreg[30:0], 1'b0};
            bitcnt <= 6'(bitcnt - 6'h01);
          end
        end
        DEV_WRITE: begin
          if (sck_rise) begin
            shreg <= {shreg[30:0], sdi_s};
            bitcnt <= 6'(bitcnt + 6'h01);
            if (bitcnt == BITS_WORD_LAST) begin
              bitcnt <= 6'h00;
              if (wr_ok) begin
                ptr <= next_wr;
              end
            end
          end
        end
        default: state <= DEV_IDLE;
      endcase
    end
  end

  // Register map writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock <= LOCK_PASSWORD;
      for (int i = CFG_LO; i <= CFG_HI; i++) begin
        cfg[i] <= (i == int'(ADDR_STATUS)) ? STATUS_RESET : 24'h000000;
      end
    end else if (wr_go && wr_ok) begin
      if (ptr == ADDR_LOCK) begin
        lock <= wr_data[23:16];
      end else if (ptr == ADDR_STATUS) begin
        cfg[ptr] <= (status & ~STATUS_WR_MASK) | (wr_data & STATUS_WR_MASK);
      end else begin
        cfg[ptr] <= wr_data;
      end
    end
  end

  // Two message words per cycle, one in the last, covers 0x09..0x1F in 12 cycles
  always_comb begin
    next_acc = arid_crc_step((crc_k == 4'h0) ? 16'h0000 : crc_acc,
      {8'h00, word_at(5'(ADDR_MSG_FIRST + {crc_k, 1'b0}), 1'b1)}, DATA_W);
    if (crc_k != CFG_CRC_LAST) begin
      next_acc = arid_crc_step(next_acc, {8'h00, word_at(5'(ADDR_MSG_FIRST + {crc_k, 1'b0} + 5'h01), 1'b1)}, DATA_W);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      crc_k <= 4'h0;
      crc_acc <= 16'h0000;
      config_checksum <= 16'h0000;
      crc_ref <= 16'h0000;
      ref_valid <= 1'b0;
      cfg_irq <= 1'b0;
    end else if (!locked) begin
      crc_k <= 4'h0;
      crc_acc <= 16'h0000;
      config_checksum <= 16'h0000;
      ref_valid <= 1'b0;
      cfg_irq <= 1'b0;
    end else begin
      crc_acc <= next_acc;
      crc_k <= (crc_k == CFG_CRC_LAST) ? 4'h0 : 4'(crc_k + 4'h1);
      if (crc_k == CFG_CRC_LAST) begin
        config_checksum <= next_acc;
        if (!ref_valid) begin
          crc_ref <= next_acc;
          ref_valid <= 1'b1;
        end else if (next_acc != crc_ref && status[ST_IRQ_EN]) begin
          cfg_irq <= 1'b1;
        end
      end
    end
  end

  // One master clock low pulse per conversion; latched low by the flag
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lnk.sample_ready_n_pin <= 1'b1;
      map_locked <= 1'b0;
    end else begin
      lnk.sample_ready_n_pin <= ~((|chan_ready) | cfg_irq);
      map_locked <= locked;
    end
  end
endmodule : arid_dev

// *** src/arid_pkg.sv ***
// Shared constants, types and CRC helper for the ADC readout integrity link
package arid_pkg;
  localparam int DATA_W = 24;
  localparam int CFG_LO = 8;
  localparam int CFG_HI = 30;
  localparam logic [4:0] ADDR_CH0 = 5'h00;
  localparam logic [4:0] ADDR_CH1 = 5'h01;
  localparam logic [4:0] ADDR_CFG_FIRST = 5'h08;
  localparam logic [4:0] ADDR_MSG_FIRST = 5'h09;
  localparam logic [4:0] ADDR_STATUS = 5'h0C;
  localparam logic [4:0] ADDR_LOCK = 5'h1F;
  localparam logic [7:0] LOCK_PASSWORD = 8'hA5;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  // Status/comm register fields
  localparam int ST_RSUM_EN = 0;
  localparam int ST_IRQ_EN = 1;
  localparam int ST_WIDTH1 = 2;
  localparam int ST_LINK = 3;
  localparam int ST_READ_LSB = 4;
  localparam int ST_WRITE = 6;
  localparam int ST_RDY_LSB = 16;
  localparam logic [23:0] STATUS_RESET = 24'h3F0028;
  localparam logic [23:0] STATUS_WR_MASK = 24'h00007F;
  localparam logic [1:0] RD_STATIC = 2'h0;
  localparam logic [1:0] RD_FULL = 2'h3;
  // Config checksum pass: 12 master clock cycles
  localparam logic [3:0] CFG_CRC_LAST = 4'hB;
  localparam logic [5:0] BITS_CTRL_LAST = 6'h07;
  localparam logic [5:0] BITS_WORD_LAST = 6'h17;
  localparam logic [5:0] BITS_CRC16_LAST = 6'h0F;
  localparam logic [5:0] BITS_CRC32_LAST = 6'h1F;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int READY_TO_OUTPUT_DELAY_NS = 100;
  localparam int READY_DELAY_CYC = (READY_TO_OUTPUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SCK_HALF_LAST = 4'h7;
  // Host register map
  localparam logic [1:0] HREG_CMD = 2'h0;
  localparam logic [1:0] HREG_WDATA = 2'h1;
  localparam logic [1:0] HREG_SEQ = 2'h2;
  localparam logic [1:0] HREG_RDATA = 2'h3;
  localparam int HCMD_READ = 5;
  localparam int HCMD_WAIT = 6;
  localparam int HSEQ_CHK = 5;
  localparam int HSEQ_CRC32 = 6;

  typedef enum logic [3:0] {
    DEV_IDLE = 4'h1,
    DEV_CTRL = 4'h2,
    DEV_READ = 4'h4,
    DEV_WRITE = 4'h8
  } arid_dev_state_type;

  typedef enum logic [3:0] {
    HST_IDLE = 4'h1,
    HST_WAIT = 4'h2,
    HST_XFER = 4'h4,
    HST_END = 4'h8
  } arid_host_state_type;

  // MSB first over the low nbits of data, zero start, no inversion
  function automatic logic [15:0] arid_crc_step(input logic [15:0] crc, input logic [31:0] data, input int nbits);
    logic [15:0] c;
    logic fb;
    c = crc;
    for (int i = 31; i >= 0; i--) begin
      if (i < nbits) begin
        fb = c[15] ^ data[i];
        c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
    end
    return c;
  endfunction : arid_crc_step
endpackage : arid_pkg

// *** src/arid_if.sv ***
// Serial link between the converter front end and its host controller
`timescale 1ns/10ps
interface arid_if;
  logic sck;
  logic cs_n;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic sample_ready_n_pin;

  modport dev(input sck, input cs_n, input sdi, output sdo, output sdo_oe, output sample_ready_n_pin);
  modport host(output sck, output cs_n, output sdi, input sdo, input sdo_oe, input sample_ready_n_pin);
endinterface : arid_if

// *** src/arid_host.sv ***
// Host end: drives the serial link and checks the read checksum
`timescale 1ns/10ps
module arid_host
  import arid_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  arid_if.host lnk,
  input wire logic [1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  arid_host_state_type state;
  logic [1:0] sdo_q;
  logic [2:0] rdy_q;
  logic [6:0] cmd;
  logic [23:0] wdata;
  logic [6:0] seq;
  logic [23:0] rdata;
  logic crc_ok;
  logic crc_err;
  logic [3:0] ph;
  logic [31:0] tx;
  logic [31:0] rx;
  logic [5:0] bitn;
  logic in_ctrl;
  logic in_crc;
  logic [4:0] words_left;
  logic [15:0] crc;
  logic [7:0] dly;
  logic start;
  logic half;
  logic [31:0] rx_next;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sdo_q <= 2'h0;
      rdy_q <= 3'h7;
    end else begin
      sdo_q <= {sdo_q[0], lnk.sdo};
      rdy_q <= {rdy_q[1:0], lnk.sample_ready_n_pin};
    end
  end

  assign start = reg_wr && reg_addr == HREG_CMD && state == HST_IDLE;
  assign half = (ph == SCK_HALF_LAST);
  assign rx_next = {rx[30:0], sdo_q[1]};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd <= 7'h00;
      wdata <= 24'h000000;
      seq <= 7'h01;
      reg_rdata <= 32'h00000000;
    end else begin
      if (start) begin
        cmd <= reg_wdata[6:0];
      end
      if (reg_wr && reg_addr == HREG_WDATA) begin
        wdata <= reg_wdata[23:0];
      end
      if (reg_wr && reg_addr == HREG_SEQ) begin
        seq <= reg_wdata[6:0];
      end
      if (reg_rd) begin
        reg_rdata <= (reg_addr == HREG_RDATA) ? {8'h00, rdata} :
          (reg_addr == HREG_CMD) ? {29'h00000000, state != HST_IDLE, crc_ok, crc_err} : 32'h00000000;
      end
    end
  end

  // Link sequencer; sck is a divided copy of clk
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= HST_IDLE;
      lnk.sck <= 1'b0;
      lnk.cs_n <= 1'b1;
      lnk.sdi <= 1'b0;
      ph <= 4'h0;
      tx <= 32'h00000000;
      rx <= 32'h00000000;
      bitn <= 6'h00;
      in_ctrl <= 1'b0;
      in_crc <= 1'b0;
      words_left <= 5'h00;
      crc <= 16'h0000;
      dly <= 8'h00;
      rdata <= 24'h000000;
      crc_ok <= 1'b0;
      crc_err <= 1'b0;
    end else begin
      ph <= half ? 4'h0 : 4'(ph + 4'h1);
      case (state)
        HST_IDLE: begin
          if (start) begin
            // Waiting for ready plus output delay avoids torn results
            state <= reg_wdata[HCMD_WAIT] ? HST_WAIT : HST_XFER;
            dly <= 8'h00;
            tx <= {2'h0, reg_wdata[4:0], reg_wdata[HCMD_READ], wdata};
            lnk.sdi <= 1'b0;
            ph <= 4'h0;
            bitn <= 6'h00;
            in_ctrl <= 1'b1;
            in_crc <= 1'b0;
            crc <= 16'h0000;
            crc_ok <= 1'b0;
            crc_err <= 1'b0;
            words_left <= (seq[4:0] == 5'h00) ? 5'h01 : seq[4:0];
          end
        end
        HST_WAIT: begin
          if (dly != 8'h00) begin
            dly <= 8'(dly + 8'h01);
            if (dly == 8'(READY_DELAY_CYC)) begin
              state <= HST_XFER;
            end
          end else if (!rdy_q[1] && rdy_q[2]) begin
            dly <= 8'h01;
          end
          ph <= 4'h0;
        end
        HST_XFER: begin
          lnk.cs_n <= 1'b0;
          if (half && !lnk.sck) begin
            lnk.sck <= 1'b1;
            rx <= rx_next;
            bitn <= 6'(bitn + 6'h01);
            if (in_ctrl && bitn == BITS_CTRL_LAST) begin
              in_ctrl <= 1'b0;
              bitn <= 6'h00;
            end else if (!in_ctrl && !cmd[HCMD_READ] && bitn == BITS_WORD_LAST) begin
              state <= HST_END;
            end else if (!in_ctrl && !in_crc && cmd[HCMD_READ] && bitn == BITS_WORD_LAST) begin
              // Whole words only, so the next result is never half read
              rdata <= rx_next[23:0];
              crc <= arid_crc_step(crc, rx_next, DATA_W);
              bitn <= 6'h00;
              words_left <= 5'(words_left - 5'h01);
              if (words_left == 5'h01) begin
                in_crc <= seq[HSEQ_CHK];
                state <= seq[HSEQ_CHK] ? HST_XFER : HST_END;
              end
            end else if (in_crc && bitn == (seq[HSEQ_CRC32] ? BITS_CRC32_LAST : BITS_CRC16_LAST)) begin
              // Zero remainder over data plus checksum, else abort
              crc_ok <= arid_crc_step(crc, rx_next, seq[HSEQ_CRC32] ? 32 : 16) == 16'h0000;
              crc_err <= arid_crc_step(crc, rx_next, seq[HSEQ_CRC32] ? 32 : 16) != 16'h0000;
              state <= HST_END;
            end
          end else if (half && lnk.sck) begin
            lnk.sck <= 1'b0;
            lnk.sdi <= tx[30];
            tx <= {tx[30:0], 1'b0};
          end else if (ph == 4'h0 && !lnk.sck && in_ctrl && bitn == 6'h00) begin
            lnk.sdi <= tx[31];
          end
        end
        HST_END: begin
          if (half && lnk.sck) begin
            lnk.sck <= 1'b0;
          end else if (half) begin
            lnk.cs_n <= 1'b1;
            state <= HST_IDLE;
          end
        end
        default: state <= HST_IDLE;
      endcase
    end
  end
endmodule : arid_host

// *** dv/arid_link_properties.sv ***
// Checker for the serial link and the device lock and checksum outputs
`timescale 1ns/10ps
module arid_link_properties (
  input logic clk,
  input logic nrst,
  input logic sck,
  input logic cs_n,
  input logic sdo,
  input logic sdo_oe,
  input logic sample_ready_n_pin,
  input logic [1:0] chan_ready,
  input logic map_locked,
  input logic cfg_irq,
  input logic [15:0] config_checksum
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  unlocked_sum_zero_a: assert property (!map_locked && $past(!map_locked) |-> config_checksum == 16'h0000)
    else $error("config checksum not zero while unlocked");
  unlocked_no_irq_a: assert property (!map_locked && $past(!map_locked) |-> !cfg_irq)
    else $error("checksum flag set while unlocked");
  irq_holds_pin_a: assert property (cfg_irq [*2] |-> !sample_ready_n_pin)
    else $error("ready pin not held low by checksum flag");
  irq_needs_lock_a: assert property ($rose(cfg_irq) |-> map_locked)
    else $error("checksum flag raised on unlocked map");
  ready_pulse_a: assert property (chan_ready != 2'b00 |-> ##[1:2] !sample_ready_n_pin)
    else $error("no ready pulse after conversion");
  pulse_short_a: assert property ($fell(sample_ready_n_pin) && !cfg_irq ##1 !cfg_irq |-> sample_ready_n_pin)
    else $error("ready pulse longer than one cycle");
  // Steady checksum between passes; a pass only ends every 12 cycles
  sum_refresh_a: assert property (map_locked && $changed(config_checksum) |=> $stable(config_checksum) [*8])
    else $error("config checksum changed inside a pass");
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock moves outside a frame");
  sck_half_a: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
    else $error("serial clock high phase not eight cycles");
  sdo_steady_a: assert property (sdo_oe && $past(sdo_oe) && sck && $past(sck) |-> $stable(sdo))
    else $error("output bit changed while clock high");
  released_oe_a: assert property (cs_n [*6] |-> !sdo_oe)
    else $error("output still driven after deselect");

  cover property ($rose(cfg_irq));
  cover property ($rose(map_locked));
  cover property ($fell(cs_n) ##[1:900] sdo_oe);
endmodule : arid_link_properties

// *** dv/tb_adc_readout_integrity_and_lock.sv ***
// Testbench joining host and device ends over the serial link
`timescale 1ns/10ps
module tb_adc_readout_integrity_and_lock;
  import arid_pkg::*;
  localparam logic [23:0] ST = 24'h00002B;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0][23:0] ch_result = '0;
  logic [1:0] chan_ready = 2'b00;
  logic map_locked;
  logic cfg_irq;
  logic [15:0] config_checksum;
  logic bq[$];
  logic [31:0] stat;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;

  arid_if lnk();
  arid_dev u_arid_dev (.clk(clk), .nrst(nrst), .lnk(lnk), .ch_result(ch_result), .chan_ready(chan_ready),
    .map_locked(map_locked), .cfg_irq(cfg_irq), .config_checksum(config_checksum));
  arid_host u_arid_host (.clk(clk), .nrst(nrst), .lnk(lnk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  arid_link_properties u_arid_link_properties (.clk(clk), .nrst(nrst), .sck(lnk.sck), .cs_n(lnk.cs_n),
    .sdo(lnk.sdo), .sdo_oe(lnk.sdo_oe), .sample_ready_n_pin(lnk.sample_ready_n_pin), .chan_ready(chan_ready),
    .map_locked(map_locked), .cfg_irq(cfg_irq), .config_checksum(config_checksum));

  always #5 clk = ~clk;

  // Wire monitor: every bit the host samples
  always @(posedge lnk.sck) begin
    if (lnk.cs_n === 1'b0) begin
      bq.push_back(lnk.sdo);
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      results();
    end
  end

  task automatic results();
    if (errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [23:0] d);
    for (int i = 23; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
    return c;
  endfunction : crc16

  function automatic logic [23:0] pat(input logic [4:0] a);
    return {3'h5, a, 8'hC3, a, 3'h2};
  endfunction : pat

  // Message of the locked map: flags as ones, checksum field as zeros
  function automatic logic [15:0] cfg_crc(input logic [7:0] lk);
    logic [15:0] c;
    c = 16'h0000;
    for (int a = 9; a < 31; a++) c = crc16(c, (a == 12) ? (24'h3F0000 | ST) : pat(a[4:0]));
    return crc16(c, {lk, 16'h0000});
  endfunction : cfg_crc

  function automatic logic [31:0] take(input int st, input int n);
    logic [31:0] v;
    v = '0;
    for (int i = 0; i < n; i++) v = {v[30:0], bq[st + i]};
    return v;
  endfunction : take

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic xfer(input logic [4:0] a, input logic rw, input logic [4:0] n, input logic [1:0] ck,
    input logic w = 1'b0);
    logic [31:0] s;
    wr(HREG_SEQ, {25'h0, ck, n});
    bq.delete();
    wr(HREG_CMD, {25'h0, w, rw, a});
    s = 32'h4;
    for (int i = 0; i < 3000 && s[2] !== 1'b0; i++) rd(HREG_CMD, s);
    // A host that never goes idle counts as a failure
    if (s[2] !== 1'b0) errors++;
    stat = s;
  endtask : xfer

  task automatic dwr(input logic [4:0] a, input logic [23:0] d);
    wr(HREG_WDATA, {8'h00, d});
    xfer(a, 1'b0, 5'h01, 2'b00);
  endtask : dwr

  task automatic pulse(input logic [1:0] m, input logic [23:0] v0, input logic [23:0] v1);
    @(posedge clk);
    ch_result <= {v1, v0};
    chan_ready <= m;
    @(posedge clk);
    chan_ready <= 2'b00;
    repeat (20) @(posedge clk); // Output delay kept before reading
  endtask : pulse

  task automatic frame_check(input logic [23:0] w0, input logic [23:0] w1, input logic [1:0] ck);
    check("word zero", take(8, 24), {8'h00, w0});
    check("word one", take(32, 24), {8'h00, w1});
    check("frame bits", bq.size(), 56 + (ck[0] ? 16 : 0) + (ck[1] ? 16 : 0));
    if (ck[0]) begin
      check("read checksum", take(56, 16), {16'h0000, crc16(crc16(16'h0000, w0), w1)});
      check("host verdict", stat[1:0], 32'h2);
      if (ck[1]) check("checksum pad", take(72, 16), 32'h0);
    end
  endtask : frame_check

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  task automatic word_check(input string nm, input logic [4:0] a, input logic [23:0] exp);
    xfer(a, 1'b1, 5'h01, 2'b00);
    check(nm, take(8, 24), {8'h00, exp});
  endtask : word_check

  initial begin
    do_reset();
    word_check("lock default", 5'h1F, 24'hA50000);
    check("reset state", {14'h0, map_locked, cfg_irq, config_checksum}, 32'h0);
    for (int a = 9; a < 31; a++) if (a != 12) dwr(a[4:0], pat(a[4:0]));
    dwr(5'h0C, ST);
    word_check("open write", 5'h09, pat(5'h09));
    pulse(2'b01, 24'hA1B2C3, 24'h5D6E7F);
    word_check("fresh flags", 5'h0C, 24'h3C0000 | ST);
    xfer(5'h00, 1'b1, 5'h02, 2'b01);
    frame_check(24'hA1B2C3, 24'h5D6E7F, 2'b01);
    word_check("read flags", 5'h0C, 24'h3F0000 | ST);
    dwr(5'h0C, ST | 24'h4);
    xfer(5'h00, 1'b1, 5'h02, 2'b11);
    frame_check(24'hA1B2C3, 24'h5D6E7F, 2'b11);
    dwr(5'h0C, ST & ~24'h1);
    xfer(5'h00, 1'b1, 5'h03, 2'b00);
    check("no checksum", take(56, 24), 32'hA1B2C3);
    dwr(5'h0C, ST & ~24'h8);
    pulse(2'b01, 24'h0C0C0C, 24'h0D0D0D);
    xfer(5'h00, 1'b1, 5'h02, 2'b00);
    frame_check(24'h0C0C0C, 24'h5D6E7F, 2'b00);
    dwr(5'h0C, ST);
    pulse(2'b01, 24'h0E0E0E, 24'h0F0F0F);
    // Second capture lands mid-word; the shifter must keep the old sample
    fork
      xfer(5'h00, 1'b1, 5'h01, 2'b00);
      begin
        repeat (300) @(posedge clk);
        pulse(2'b11, 24'h707070, 24'h818181);
      end
    join
    check("frozen word", take(8, 24), 32'h0E0E0E);
    dwr(5'h00, 24'h123456);
    xfer(5'h00, 1'b1, 5'h02, 2'b01);
    frame_check(24'h707070, 24'h818181, 2'b01);
    // Late conversion: only a host that waits for the ready fall sees it
    fork
      xfer(5'h00, 1'b1, 5'h02, 2'b01, 1'b1);
      begin
        repeat (400) @(posedge clk);
        pulse(2'b01, 24'h313131, 24'h424242);
      end
    join
    frame_check(24'h313131, 24'h424242, 2'b01);
    dwr(5'h0C, ST | 24'h10);
    xfer(5'h1E, 1'b1, 5'h02, 2'b01);
    check("full set end", take(32, 24), 32'hA50000);
    check("full set sum", take(56, 16), {16'h0, crc16(crc16(16'h0000, pat(5'h1E)), 24'hA50000)});
    dwr(5'h0C, ST & ~24'h20);
    xfer(5'h09, 1'b1, 5'h01, 2'b01);
    check("static sum", take(32, 16), {16'h0, crc16(16'h0000, pat(5'h09))});
    check("static verdict", stat[1:0], 32'h2);
    dwr(5'h0C, ST);
    dwr(5'h1F, 24'h000000);
    repeat (30) @(posedge clk);
    check("first lock", {14'h0, map_locked, cfg_irq, config_checksum}, {16'h0002, cfg_crc(8'h00)});
    dwr(5'h09, 24'h0F0F0F);
    word_check("locked write", 5'h09, pat(5'h09));
    dwr(5'h1F, 24'h3C0000);
    repeat (30) @(posedge clk);
    check("changed map", {14'h0, map_locked, cfg_irq, config_checksum}, {16'h0003, cfg_crc(8'h3C)});
    check("latched pin", {31'h0, lnk.sample_ready_n_pin}, 32'h0);
    dwr(5'h1F, 24'hA50000);
    repeat (5) @(posedge clk);
    check("unlocked", {14'h0, map_locked, cfg_irq, config_checksum}, 32'h0);
    dwr(5'h09, 24'h0F0F0F);
    word_check("reopened write", 5'h09, 24'h0F0F0F);
    dwr(5'h1F, 24'h000000);
    repeat (30) @(posedge clk);
    do_reset();
    check("after reset", {14'h0, map_locked, cfg_irq, config_checksum}, 32'h0);
    word_check("lock restored", 5'h1F, 24'hA50000);
    results();
  end
endmodule : tb_adc_readout_integrity_and_lock
